// ---- src/cmc_cfg.svh ----
// Constants for the configuration memory CRC checker.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH
`define CMC_CRC_W        32
`define CMC_CRC_POLY     32'h04C11DB7
`define CMC_CRC_INIT     32'hFFFFFFFF
`define CMC_IR_W         10
`define CMC_IR_LOAD_CHK  10'h015
`define CMC_IR_BYPASS    10'h3FF
`define CMC_MEM_WORDS    64
`define CMC_MEM_AW       6
`define CMC_DIV_DEF      8'h02
`define CMC_DIV_W        8
`define CMC_ZERO_ADDR    6'h00
`endif

// ---- src/cmc_pkg.sv ----
// Types shared by the configuration memory CRC checker.
// Assumes cmc_cfg.svh is on the include path.
package cmc_pkg;
  typedef enum logic [1:0] {CMC_IDLE, CMC_SCAN, CMC_DONE} cmc_scan_t;
  typedef enum logic [1:0] {CMC_CFG, CMC_USER} cmc_mode_t;
endpackage

// ---- src/cmc_crc_if.sv ----
// Interface carrying one CRC step request and its result.
// Assumes one clock domain shared by both modules.
`include "cmc_cfg.svh"
interface cmc_crc_if;
  logic                  step;
  logic                  clear;
  logic [`CMC_CRC_W-1:0] data;
  logic [`CMC_CRC_W-1:0] crc;
  modport master (output step, output clear, output data, input crc);
  modport engine (input step, input clear, input data, output crc);
endinterface

// ---- src/cmc_crc_engine.sv ----
// Word-wide CRC-32 accumulator, one memory word per step.
// Assumes the caller clears it before each pass.
`include "cmc_cfg.svh"
module cmc_crc_engine
  import cmc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  cmc_crc_if.engine crc_port
);
  logic [`CMC_CRC_W-1:0] acc_q;
  logic [`CMC_CRC_W-1:0] acc_d;

  ////////////////////////////////////////////////////////////////////
  // Bitwise next value; a full word per cycle keeps the pass short
  always_comb
  begin
    acc_d = acc_q;
    for (int i = `CMC_CRC_W - 1; i >= 0; i--)
    begin
      if (acc_d[`CMC_CRC_W-1] ^ crc_port.data[i])
        acc_d = (acc_d << 1) ^ `CMC_CRC_POLY;
      else
        acc_d = acc_d << 1;
    end
  end

  // Accumulator register
  always_ff @(posedge mclk)
  begin
    if (sys_rst || crc_port.clear)
      acc_q <= `CMC_CRC_INIT;
    else if (crc_port.step)
      acc_q <= acc_d;
  end

  assign crc_port.crc = acc_q;
endmodule

// ---- src/cmc_checker.sv ----
// Configuration memory CRC checker with JTAG access to the reference.
// Assumes JTAG TAP signals are synchronous to mclk (state decoded outside)
// and that config memory reads return data one cycle after the address.
//
// Functional notes
// - Load-check instruction places the 32-bit reference register between TDI and TDO.
// - Load-check instruction only honoured in user mode after configuration.
// - Shifted-in value replaces the reference used by the comparison.
// - Checker can be exercised in-system without reconfiguration.
// - Reference computed during configuration, compared against fresh CRC later.
// - CRC is 32-bit over all configuration memory words.
// - Check pass repeats continuously in user mode while ed_enable or cfg_done is high.
// - Error output goes high when fresh CRC differs from reference.
// - Error output driven only when detection is enabled, else pin free.
// - Pass time set by the divided error-detection clock rate.
`include "cmc_cfg.svh"
module cmc_checker
  import cmc_pkg::*;
#(
  parameter int MEM_WORDS = `CMC_MEM_WORDS,
  parameter int AW        = `CMC_MEM_AW
)
(
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  cfg_done,
  input  wire logic                  reconfigure_request_n,
  input  wire logic                  ed_enable,
  input  wire logic [`CMC_DIV_W-1:0] ed_divisor,
  input  wire logic [`CMC_CRC_W-1:0] config_memory_rdata,
  output logic      [AW-1:0]         config_memory_addr,
  input  wire logic                  tck_rise,
  input  wire logic                  tap_capture_dr,
  input  wire logic                  tap_shift_dr,
  input  wire logic                  tap_update_ir,
  input  wire logic [`CMC_IR_W-1:0]  tap_ir_shadow,
  input  wire logic                  tdi,
  output logic                       tdo,
  output logic                       tdo_oe,
  output logic                       crc_error_o,
  output logic                       crc_error_oe,
  output logic                       pass_done
);
  cmc_crc_if crc_bus ();

  cmc_mode_t             mode_q;
  cmc_scan_t             scan_q;
  logic [`CMC_IR_W-1:0]  ir_q;
  logic [`CMC_CRC_W-1:0] ref_q;
  logic [`CMC_DIV_W-1:0] div_q;
  logic [`CMC_DIV_W-1:0] div_cnt_q;
  logic                  tick_q;
  logic [AW-1:0]         addr_q;
  logic                  rd_valid_q;
  logic                  last_q;
  logic                  ref_pass_q;
  logic                  load_sel;

  cmc_crc_engine u_crc
  (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .crc_port (crc_bus.engine)
  );

  ////////////////////////////////////////////////////////////////////
  // Mode: configuration until done, user afterwards; reconfig restarts
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !reconfigure_request_n)
      mode_q <= CMC_CFG;
    else if (cfg_done)
      mode_q <= CMC_USER;
  end

  // Instruction latched at update-IR
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ir_q <= `CMC_IR_BYPASS;
    else if (tck_rise && tap_update_ir)
      ir_q <= tap_ir_shadow;
  end

  // Only honoured in user mode; in configuration it reads as bypass
  assign load_sel = (ir_q == `CMC_IR_LOAD_CHK) && (mode_q == CMC_USER);

  ////////////////////////////////////////////////////////////////////
  // Error-detection clock divider; divisor captured at pass start so
  // a change mid-pass cannot stretch one pass unevenly
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      div_q <= `CMC_DIV_DEF;
    else if (scan_q != CMC_SCAN)
      div_q <= (ed_divisor == '0) ? `CMC_DIV_DEF : ed_divisor;
  end

  // Tick once every div_q cycles; pass time scales with it
  always_ff @(posedge mclk)
  begin
    if (sys_rst || div_cnt_q == div_q - 1'b1)
      div_cnt_q <= '0;
    else
      div_cnt_q <= div_cnt_q + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      tick_q <= 1'b0;
    else
      tick_q <= (div_cnt_q == div_q - 1'b1);
  end

  ////////////////////////////////////////////////////////////////////
  // Scan sequencer: one word per tick over the whole memory
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !reconfigure_request_n)
    begin
      scan_q     <= CMC_IDLE;
      addr_q     <= `CMC_ZERO_ADDR;
      ref_pass_q <= 1'b1;
    end
    else
    begin
      unique case (scan_q)
        CMC_IDLE:
          if (cfg_done || (mode_q == CMC_USER && ed_enable))
          begin
            scan_q     <= CMC_SCAN;
            addr_q     <= `CMC_ZERO_ADDR;
            ref_pass_q <= (mode_q == CMC_CFG);
          end
        CMC_SCAN:
          if (tick_q)
          begin
            if (addr_q == AW'(MEM_WORDS - 1))
              scan_q <= CMC_DONE;
            else
              addr_q <= addr_q + 1'b1;
          end
        CMC_DONE:
          if (!rd_valid_q)
            scan_q <= CMC_IDLE;
      endcase
    end
  end

  // Read data arrives a cycle after the address
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rd_valid_q <= 1'b0;
      last_q     <= 1'b0;
    end
    else
    begin
      rd_valid_q <= (scan_q == CMC_SCAN) && tick_q;
      last_q     <= (scan_q == CMC_SCAN) && tick_q && (addr_q == AW'(MEM_WORDS - 1));
    end
  end

  assign crc_bus.step  = rd_valid_q;
  assign crc_bus.data  = config_memory_rdata;
  assign crc_bus.clear = (scan_q == CMC_IDLE);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      config_memory_addr <= `CMC_ZERO_ADDR;
    else
      config_memory_addr <= addr_q;
  end

  ////////////////////////////////////////////////////////////////////
  // Reference register: set at the configuration pass, shiftable by JTAG
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ref_q <= '0;
    else if (tck_rise && load_sel && tap_shift_dr)
      ref_q <= {tdi, ref_q[`CMC_CRC_W-1:1]};
    else if (scan_q == CMC_DONE && !rd_valid_q && ref_pass_q)
      ref_q <= crc_bus.crc;
  end

  // TDO shows the reference LSB while selected
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo    <= load_sel ? ref_q[0] : tdi;
      tdo_oe <= tap_shift_dr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Compare at end of each user pass; error sticks until next pass
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !reconfigure_request_n)
      crc_error_o <= 1'b0;
    else if (scan_q == CMC_DONE && !rd_valid_q && !ref_pass_q)
      crc_error_o <= (crc_bus.crc != ref_q);
  end

  // Open-drain active high: enable only when detection on; else pin free
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      crc_error_oe <= 1'b0;
    else
      crc_error_oe <= ed_enable && (mode_q == CMC_USER);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      pass_done <= 1'b0;
    else
      pass_done <= (scan_q == CMC_DONE) && !rd_valid_q && !last_q;
  end
endmodule

// ---- bench/cmc_mem_model.sv ----
// Configuration memory seen from the checker: registered read port.
// Assumes the bench fills and corrupts the array by hierarchy.
`include "cmc_cfg.svh"
module cmc_mem_model
(
  input  wire logic                  mclk,
  input  wire logic [`CMC_MEM_AW-1:0] addr,
  output logic      [`CMC_CRC_W-1:0]  rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [`CMC_CRC_W-1:0] mem [`CMC_MEM_WORDS];
  // Data lands one cycle after the address, every word readable
  always @(posedge mclk)
    rdata <= mem[addr];
endmodule

// ---- bench/cmc_checker_sva.sv ----
// Concurrent checks on the checker's top ports.
// Assumes one clock domain and a synchronous active-high reset.
`include "cmc_cfg.svh"
module cmc_checker_sva #(parameter int MEM_WORDS = `CMC_MEM_WORDS)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cfg_done,
  input wire logic reconfigure_request_n,
  input wire logic ed_enable,
  input wire logic tap_shift_dr,
  input wire logic tdo_oe,
  input wire logic crc_error_o,
  input wire logic crc_error_oe,
  input wire logic pass_done
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RUN_MAX = MEM_WORDS * 1024;
  int gap_q;
  int run_q;
  // Cycle counts since a pass ended; the live one is held at zero while checking is off
  always_ff @(posedge mclk)
  begin
    gap_q <= (sys_rst || pass_done) ? 0 : gap_q + 1;
    run_q <= (sys_rst || pass_done || !crc_error_oe) ? 0 : run_q + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_reconf;
    !reconfigure_request_n ##1 1'b1;
  endsequence
  property p_oe_gate; crc_error_oe |-> $past(ed_enable); endproperty
  property p_err_rise; $rose(crc_error_o) |-> pass_done || $past(pass_done); endproperty
  property p_reconf; s_reconf |-> !crc_error_o; endproperty
  property p_cfg_gate; !cfg_done |-> ##2 !crc_error_oe; endproperty
  property p_shift_oe; tap_shift_dr |=> tdo_oe; endproperty
  property p_gap; pass_done |-> gap_q >= MEM_WORDS; endproperty
  property p_run; run_q < RUN_MAX; endproperty
  property p_pulse; pass_done |=> !pass_done; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("error pin enabled without enable");
  a_err_rise: assert property (p_err_rise) else $error("error rose off pass end");
  a_reconf: assert property (p_reconf) else $error("error kept over reconfigure");
  a_cfg_gate: assert property (p_cfg_gate) else $error("checking live in config mode");
  a_shift_oe: assert property (p_shift_oe) else $error("serial out not driven");
  a_gap: assert property (p_gap) else $error("pass shorter than memory");
  a_run: assert property (p_run) else $error("checking stalled");
  a_pulse: assert property (p_pulse) else $error("pass end not a pulse");
endmodule
bind cmc_checker cmc_checker_sva #(.MEM_WORDS(MEM_WORDS)) u_sva (.mclk(mclk), .sys_rst(sys_rst),
  .cfg_done(cfg_done), .reconfigure_request_n(reconfigure_request_n), .ed_enable(ed_enable),
  .tap_shift_dr(tap_shift_dr), .tdo_oe(tdo_oe), .crc_error_o(crc_error_o),
  .crc_error_oe(crc_error_oe), .pass_done(pass_done));

// ---- bench/tb_config_memory_crc_checker.sv ----
// Self-checking bench: passes, corruption, reference load, refusal, reconfigure.
// Assumes the memory model and the bound checker are compiled alongside.
`include "cmc_cfg.svh"
module tb_config_memory_crc_checker;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, sys_rst = 1, cfg_done = 0, reconf_n = 1, ed_enable = 0;
  logic tck_rise = 0, shift_dr = 0, upd_ir = 0, tdi = 0, cap_dr = 0;
  logic tdo, tdo_oe, err, err_oe, pass_done;
  logic [7:0] div = 8'h08;
  logic [9:0] ir = `CMC_IR_BYPASS;
  logic [5:0] addr;
  logic [31:0] rdata, v;
  int n_fail = 0, tests_run = 0;
  logic exp_q [$];
  always #25 mclk = ~mclk;
  cmc_checker dut (.mclk(mclk), .sys_rst(sys_rst), .cfg_done(cfg_done),
    .reconfigure_request_n(reconf_n), .ed_enable(ed_enable), .ed_divisor(div),
    .config_memory_rdata(rdata), .config_memory_addr(addr), .tck_rise(tck_rise),
    .tap_capture_dr(cap_dr), .tap_shift_dr(shift_dr), .tap_update_ir(upd_ir),
    .tap_ir_shadow(ir), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .crc_error_o(err),
    .crc_error_oe(err_oe), .pass_done(pass_done));
  cmc_mem_model far (.mclk(mclk), .addr(addr), .rdata(rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for the next pass end, so a stalled scan cannot hang the run
  task automatic wait_pass;
    @(negedge mclk);
    for (int i = 0; pass_done !== 1'b1; i++)
    begin
      if (i > 40000)
      begin
        n_fail++;
        summarize();
      end
      @(negedge mclk);
    end
    // One more cycle so a following note cannot race the monitor at this pass end
    @(negedge mclk);
  endtask
  task automatic load_ir(input logic [9:0] code);
    ir = code;
    upd_ir = 1;
    tck_rise = 1;
    @(negedge mclk);
    upd_ir = 0;
    cap_dr = 1;
    @(negedge mclk);
    cap_dr = 0;
    tck_rise = 0;
    shift_dr = 1;
    @(negedge mclk);
  endtask
  // Mode 1 expects the stored value rotating out, mode 2 expects tdi echoed
  task automatic shift(input logic [31:0] val, input int mode);
    for (int k = 0; k < 32; k++)
    begin
      tdi = val[k];
      tck_rise = 1;
      @(negedge mclk);
      tck_rise = 0;
      @(negedge mclk);
      if (mode != 0)
        chk(tdo, (mode == 1) ? val[(k + 1) % 32] : val[k]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Error is read a cycle after each pass end with an expectation queued, where it must be settled
  always @(negedge mclk)
    if (pass_done === 1'b1 && exp_q.size() > 0)
    begin
      @(negedge mclk);
      chk(err, exp_q.pop_front());
    end
  initial
  begin
    repeat (100000) @(negedge mclk);
    n_fail++;
    summarize();
  end
  initial
  begin
    void'($urandom(32'h1B988B7F));
    for (int i = 0; i < 64; i++)
      far.mem[i] = $urandom;
    div = 8'h08 + 8'($urandom % 8);
    v = $urandom;
    repeat (20) @(negedge mclk);
    sys_rst = 0;
    ed_enable = 1;
    cfg_done = 1;
    wait_pass();
    exp_q.push_back(1'b0);
    wait_pass();
    chk(err_oe, 1'b1);
    far.mem[63] = ~far.mem[63];
    exp_q.push_back(1'b1);
    wait_pass();
    far.mem[63] = ~far.mem[63];
    exp_q.push_back(1'b0);
    wait_pass();
    // Reference replaced in user mode, no reconfigure in between
    load_ir(`CMC_IR_LOAD_CHK);
    shift(v, 0);
    shift(v, 1);
    exp_q.push_back(1'b1);
    wait_pass();
    cfg_done = 0;
    reconf_n = 0;
    @(negedge mclk);
    reconf_n = 1;
    @(negedge mclk);
    chk(err, 1'b0);
    load_ir(`CMC_IR_LOAD_CHK);
    shift(~v, 2);
    cfg_done = 1;
    wait_pass();
    exp_q.push_back(1'b0);
    wait_pass();
    ed_enable = 0;
    repeat (3) @(negedge mclk);
    chk(err_oe, 1'b0);
    summarize();
  end
endmodule
